/* File: pkg/lpc_pkg.sv */
// Shared constants and types for the link-side PHY port block
package lpc_pkg;

	////////////////////////////////////////////////////////////////////
	// Clock and timing
	// Local clock rate in kHz (PHY supplied system clock)
	localparam int CLK_FREQ_KHZ = 50000;
	// Link power status: frequency in kHz and high share in percent
	localparam int LPS_FREQ_KHZ = 1400;
	localparam int LPS_DUTY_PCT = 25;
	// Period rounds down, so the rate never falls under the target
	localparam int LPS_PERIOD_CYC = CLK_FREQ_KHZ / LPS_FREQ_KHZ;
	localparam int LPS_HIGH_CYC = LPS_PERIOD_CYC * LPS_DUTY_PCT / 100;
	// Bus cycle period in microseconds (8 kHz cycle clock)
	localparam int CYCLE_PERIOD_US = 125;
	localparam int CYCLE_CYC = CYCLE_PERIOD_US * (CLK_FREQ_KHZ / 1000);

	////////////////////////////////////////////////////////////////////
	// Lane and control encodings
	// Speed codes for the data lanes
	localparam logic [1:0] SPD_100 = 2'h0;
	localparam logic [1:0] SPD_200 = 2'h1;
	localparam logic [1:0] SPD_400 = 2'h2;
	// PHY control line states seen by the link
	localparam logic [1:0] CTL_IDLE = 2'h0;
	localparam logic [1:0] CTL_RECEIVE = 2'h2;
	localparam logic [1:0] CTL_GRANT = 2'h3;
	// Link request frame lengths, start bit included
	localparam logic [3:0] LREQ_LEN_LEGACY = 4'h8;
	localparam logic [3:0] LREQ_LEN_AMENDED = 4'hC;
	// Width of the pin bundle that passes the synchroniser
	localparam int PIN_W = 16;

	////////////////////////////////////////////////////////////////////
	// Types
	// Retained configuration, loaded by the host
	typedef struct packed {
		logic [1:0] speed; // Lane speed code
		logic ext_cycle; // Follow the external cycle start
		logic software_power_down_bit; // Power down by software
		logic phy_link_reset_bit; // Hold link datapath idle
	} lpc_cfg_t;

	// Pin inputs crossing into the local clock domain
	typedef struct packed {
		logic power_down_input;
		logic link_on;
		logic cycle_start;
		logic lane_clk;
		logic legacy_phy;
		logic isolation_barrier_select;
		logic [1:0] ctl;
		logic [7:0] data; // Bit 7 carries lane 0
	} lpc_pins_t;

	// Link request state machine
	typedef enum logic [1:0] {
		LQ_IDLE = 2'b01,
		LQ_SEND = 2'b10
	} lpc_lreq_st_t;

endpackage

/* File: rtl/lpc_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
// Small synchronous FIFO with valid and ready on both sides
module lpc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Fill side
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	// Drain side
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// Refuse shapes the pointer logic cannot serve
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
		$error("lpc_fifo: DEPTH must be a power of two >= 2");
	end

	// Storage and pointers
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic [AW:0] count_nxt;

	// Handshakes that move a word
	wire push = in_valid_in && in_ready_out;
	wire pop = out_valid_out && out_ready_in;

	assign out_valid_out = (count_r != '0);
	assign out_data_out = mem[rd_ptr_r];
	assign count_nxt = count_r + (AW + 1)'(push) - (AW + 1)'(pop);

	////////////////////////////////////////////////////////////////////
	// Ready is registered so the top sees it straight from a flop
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
			in_ready_out <= 1'b1;
		end else begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			count_r <= count_nxt;
			in_ready_out <= (count_nxt != (AW + 1)'(DEPTH));
		end
	end

	// Data array needs no reset
	always_ff @(posedge clk_in) begin
		if (push)
			mem[wr_ptr_r] <= in_data_in;
	end

endmodule
`default_nettype wire

/* File: rtl/lpc_port.sv */
// Contract
// RQ1 - Lane zero carries the byte's most significant bit
// RQ2 - Two, four or eight lanes per speed
// RQ3 - Generation pin high means legacy PHY
// RQ4 - Link request line asks arbitration and register access
// RQ5 - Link power status near 1.4 MHz, 25% high
// RQ6 - Link-on from PHY raises host interrupt
// RQ7 - Isolation pin low legacy barrier, high bushold
// RQ8 - Power down enters low power, stops LPS
// RQ9 - Host leaves configuration alone during power down
// RQ10 - Configuration survives power down unchanged
// RQ11 - Runs on the PHY supplied system clock
// RQ12 - Auxiliary clock equals the system clock
// RQ13 - External cycle start can mark bus cycles
// RQ14 - Cycle start output copies 8 kHz cycle clock
// RQ15 - Host stops isochronous transmit before power down
// RQ16 - Host empties asynchronous queues before power down
// RQ17 - LPS held low while powered down
// RQ18 - Pin inputs synchronised before use
`timescale 1ns/10ps
`default_nettype none
module lpc_port #(
	// Local clocks per bus cycle; shorten for simulation
	parameter int CYCLE_CYC = lpc_pkg::CYCLE_CYC,
	// Transmit buffer depth
	parameter int TX_DEPTH = 4
) (
	// System clock from the PHY and reset
	input wire logic mclk_in, // see RQ11
	input wire logic resetn_in,
	// Host configuration port
	input wire logic cfg_wr_in,
	input wire lpc_pkg::lpc_cfg_t cfg_in,
	output lpc_pkg::lpc_cfg_t cfg_out,
	output logic low_power_out,
	// Host transmit bytes
	input wire logic tx_valid_in,
	input wire logic [7:0] tx_data_in,
	output logic tx_ready_out,
	// Host receive bytes
	output logic rx_valid_out,
	output logic [7:0] rx_data_out,
	// Host link request
	input wire logic lreq_go_in,
	input wire logic [10:0] lreq_bits_in,
	output logic lreq_busy_out,
	// Host events
	output logic link_on_irq_out,
	output logic cycle_tick_out,
	// PHY pins
	input wire logic [0:7] phy_data_in,
	output logic [0:7] phy_data_out,
	output logic phy_data_oe_out,
	input wire logic [0:1] phy_ctl_in,
	input wire logic phy_lane_clk_in,
	output logic lreq_out,
	output logic lps_out,
	input wire logic link_on_in,
	input wire logic legacy_phy_in,
	input wire logic isolation_barrier_select,
	output logic legacy_mode_out,
	output logic bushold_en_out,
	input wire logic power_down_input,
	output logic aux_clock_out,
	input wire logic cycle_start_in,
	output logic cycle_start_out
);

	// Refuse values the counters cannot serve
	if (CYCLE_CYC < 4 || CYCLE_CYC > 65535) begin : g_bad_cycle
		$error("lpc_port: CYCLE_CYC out of range");
	end

	////////////////////////////////////////////////////////////////////
	// Pin synchronisation
	lpc_pkg::lpc_pins_t pins_raw;
	lpc_pkg::lpc_pins_t pins;

	// Lane 0 lands in bit 7 of the packed field
	assign pins_raw = '{
		power_down_input: power_down_input,
		link_on: link_on_in,
		cycle_start: cycle_start_in,
		lane_clk: phy_lane_clk_in,
		legacy_phy: legacy_phy_in,
		isolation_barrier_select: isolation_barrier_select,
		ctl: phy_ctl_in,
		data: phy_data_in
	};

	// Every pin passes two flops before any logic reads it
	lpc_sync2 #(
		.WIDTH(lpc_pkg::PIN_W)
	) u_sync (
		.clk_in(mclk_in),
		.resetn_in(resetn_in),
		.async_in(pins_raw),
		.sync_out(pins)
	); // see RQ18

	// Delayed copies for edge detection
	logic link_on_d_r;
	logic cycle_d_r;
	logic lane_clk_d_r;

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			link_on_d_r <= 1'b0;
			cycle_d_r <= 1'b0;
			lane_clk_d_r <= 1'b0;
		end else begin
			link_on_d_r <= pins.link_on;
			cycle_d_r <= pins.cycle_start;
			lane_clk_d_r <= pins.lane_clk;
		end
	end

	wire link_on_rise = pins.link_on && !link_on_d_r;
	wire cycle_rise = pins.cycle_start && !cycle_d_r;
	wire lane_edge = pins.lane_clk && !lane_clk_d_r;

	////////////////////////////////////////////////////////////////////
	// Configuration and power state
	lpc_pkg::lpc_cfg_t cfg_r;

	// Power down by pin or by software bit
	wire pd_now = pins.power_down_input || cfg_r.software_power_down_bit;
	// Link datapath runs only when powered and not held in reset
	wire active = !pd_now && !cfg_r.phy_link_reset_bit;

	// Writes are honoured only while the pin is low; the host is trusted
	// to stay quiet meanwhile, this guard only protects the retained copy
	wire cfg_take = cfg_wr_in && !pins.power_down_input; // see RQ9

	// Configuration is never cleared by power down, only by reset
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			cfg_r <= '0;
		else if (cfg_take)
			cfg_r <= cfg_in; // see RQ10
	end

	// Status copies for the host and mode pins toward the pads
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cfg_out <= '0;
			low_power_out <= 1'b0;
			legacy_mode_out <= 1'b0;
			bushold_en_out <= 1'b0;
		end else begin
			cfg_out <= cfg_r;
			low_power_out <= pd_now; // see RQ8
			legacy_mode_out <= pins.legacy_phy; // see RQ3
			// Low selects the legacy barrier, high turns on bushold
			bushold_en_out <= pins.isolation_barrier_select; // see RQ7
		end
	end

	// Forwarded clock; a flop cannot reproduce its own clock rate
	assign aux_clock_out = mclk_in; // see RQ12

	////////////////////////////////////////////////////////////////////
	// Link power status generator
	logic [5:0] lps_cnt_r;

	localparam logic [5:0] LPS_LAST = 6'(lpc_pkg::LPS_PERIOD_CYC - 1);
	localparam logic [5:0] LPS_HIGH = 6'(lpc_pkg::LPS_HIGH_CYC);

	// Counter parks at zero in power down so LPS restarts cleanly
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			lps_cnt_r <= 6'h00;
			lps_out <= 1'b0;
		end else if (pd_now) begin
			lps_cnt_r <= 6'h00;
			lps_out <= 1'b0; // see RQ8, see RQ17
		end else begin
			lps_cnt_r <= (lps_cnt_r == LPS_LAST) ? 6'h00 : lps_cnt_r + 6'h01;
			lps_out <= (lps_cnt_r < LPS_HIGH); // see RQ5
		end
	end

	////////////////////////////////////////////////////////////////////
	// Link-on interrupt; stays alive in power down to wake the host
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			link_on_irq_out <= 1'b0;
		else
			link_on_irq_out <= link_on_rise; // see RQ6
	end

	////////////////////////////////////////////////////////////////////
	// Bus cycle timer
	logic [15:0] cyc_cnt_r;

	localparam logic [15:0] CYC_LAST = 16'(CYCLE_CYC - 1);
	localparam logic [15:0] CYC_HALF = 16'(CYCLE_CYC / 2);

	// External start restarts the count when selected
	wire cyc_restart = cfg_r.ext_cycle ? cycle_rise : (cyc_cnt_r == CYC_LAST);

	// Without external starts selected the timer free-runs at its own period; with them it waits at its last count
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cyc_cnt_r <= 16'h0000;
			cycle_tick_out <= 1'b0;
			cycle_start_out <= 1'b0;
		end else begin
			if (cyc_restart)
				cyc_cnt_r <= 16'h0000; // see RQ13
			else if (cyc_cnt_r != CYC_LAST)
				cyc_cnt_r <= cyc_cnt_r + 16'h0001;
			cycle_tick_out <= cyc_restart;
			// High for the first half of each cycle
			cycle_start_out <= (cyc_cnt_r < CYC_HALF); // see RQ14
		end
	end

	////////////////////////////////////////////////////////////////////
	// Link request serialiser
	lpc_pkg::lpc_lreq_st_t lq_st_r;
	logic [11:0] lq_sh_r;
	logic [3:0] lq_cnt_r;

	// Frame length follows the PHY generation
	wire [3:0] lq_len = pins.legacy_phy ? lpc_pkg::LREQ_LEN_LEGACY :
		lpc_pkg::LREQ_LEN_AMENDED; // see RQ3
	// Start bit first, payload MSB first, unused tail zero
	wire [11:0] lq_load = pins.legacy_phy ?
		{1'b1, lreq_bits_in[6:0], 4'h0} : {1'b1, lreq_bits_in};

	// One bit per clock, then the line returns low
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			lq_st_r <= lpc_pkg::LQ_IDLE;
			lq_sh_r <= 12'h000;
			lq_cnt_r <= 4'h0;
			lreq_out <= 1'b0;
		end else begin
			case (lq_st_r)
				lpc_pkg::LQ_IDLE: begin
					lreq_out <= 1'b0;
					if (lreq_go_in && active) begin
						lq_sh_r <= lq_load;
						lq_cnt_r <= lq_len;
						lq_st_r <= lpc_pkg::LQ_SEND;
					end
				end
				lpc_pkg::LQ_SEND: begin
					lreq_out <= lq_sh_r[11]; // see RQ4
					lq_sh_r <= {lq_sh_r[10:0], 1'b0};
					lq_cnt_r <= lq_cnt_r - 4'h1;
					if (lq_cnt_r == 4'h1 || !active)
						lq_st_r <= lpc_pkg::LQ_IDLE; // see RQ8
				end
				default: begin
					lq_st_r <= lpc_pkg::LQ_IDLE;
					lreq_out <= 1'b0;
				end
			endcase
		end
	end

	assign lreq_busy_out = lreq_out;

	////////////////////////////////////////////////////////////////////
	// Transmit buffer; its ready reaches the host directly
	logic fifo_valid;
	logic [7:0] fifo_data;
	logic fifo_pop;

	lpc_fifo #(
		.WIDTH(8),
		.DEPTH(TX_DEPTH)
	) u_txfifo (
		.clk_in(mclk_in),
		.resetn_in(resetn_in),
		.in_valid_in(tx_valid_in),
		.in_data_in(tx_data_in),
		.in_ready_out(tx_ready_out),
		.out_valid_out(fifo_valid),
		.out_data_out(fifo_data),
		.out_ready_in(fifo_pop)
	);

	////////////////////////////////////////////////////////////////////
	// Lane packing shared by both directions
	wire [1:0] spd = cfg_r.speed;
	// Lane clock edges per byte: 4, 2 or 1
	wire [2:0] chunks = (spd == lpc_pkg::SPD_400) ? 3'h1 :
		(spd == lpc_pkg::SPD_200) ? 3'h2 : 3'h4; // see RQ2

	// Transmit shifter state
	logic [7:0] tx_sh_r;
	logic [2:0] tx_cnt_r;

	wire granted = (pins.ctl == lpc_pkg::CTL_GRANT);
	wire tx_step = lane_edge && active && granted;
	wire tx_have = (tx_cnt_r != 3'h0) || fifo_valid;
	// Current byte comes from the buffer at the start of each byte
	wire [7:0] tx_cur = (tx_cnt_r == 3'h0) ? fifo_data : tx_sh_r;
	assign fifo_pop = tx_step && (tx_cnt_r == 3'h0) && fifo_valid;

	// Top bits go on the lowest numbered lanes, unused lanes zero
	wire [0:7] tx_lanes = (spd == lpc_pkg::SPD_400) ? tx_cur :
		(spd == lpc_pkg::SPD_200) ? {tx_cur[7:4], 4'h0} :
		{tx_cur[7:6], 6'h00}; // see RQ1, see RQ2
	wire [7:0] tx_shifted = (spd == lpc_pkg::SPD_400) ? 8'h00 :
		(spd == lpc_pkg::SPD_200) ? {tx_cur[3:0], 4'h0} :
		{tx_cur[5:0], 2'h0};

	// Drive lanes only while granted and data waits
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tx_sh_r <= 8'h00;
			tx_cnt_r <= 3'h0;
			phy_data_out <= 8'h00;
			phy_data_oe_out <= 1'b0;
		end else if (!active || !granted) begin
			// Partial byte is dropped when the grant goes away
			tx_cnt_r <= 3'h0;
			phy_data_oe_out <= 1'b0;
		end else if (tx_step) begin
			if (tx_have) begin
				phy_data_out <= tx_lanes;
				phy_data_oe_out <= 1'b1;
				tx_sh_r <= tx_shifted;
				tx_cnt_r <= (tx_cnt_r == 3'h0) ? chunks - 3'h1 :
					tx_cnt_r - 3'h1;
			end else begin
				phy_data_oe_out <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Receive assembler
	logic [7:0] rx_sh_r;
	logic [2:0] rx_cnt_r;

	wire receiving = (pins.ctl == lpc_pkg::CTL_RECEIVE);
	wire rx_step = lane_edge && active && receiving && !phy_data_oe_out;
	// Lane 0 is the most significant bit of each chunk
	wire [7:0] rx_next = (spd == lpc_pkg::SPD_400) ? pins.data :
		(spd == lpc_pkg::SPD_200) ? {rx_sh_r[3:0], pins.data[7:4]} :
		{rx_sh_r[5:0], pins.data[7:6]}; // see RQ1, see RQ2
	wire rx_done = rx_step && (rx_cnt_r == chunks - 3'h1);

	// Count restarts whenever the PHY leaves receive
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rx_sh_r <= 8'h00;
			rx_cnt_r <= 3'h0;
			rx_valid_out <= 1'b0;
			rx_data_out <= 8'h00;
		end else begin
			rx_valid_out <= rx_done;
			if (!receiving || !active) begin
				rx_cnt_r <= 3'h0;
			end else if (rx_step) begin
				rx_sh_r <= rx_next;
				rx_cnt_r <= rx_done ? 3'h0 : rx_cnt_r + 3'h1;
			end
			if (rx_done)
				rx_data_out <= rx_next;
		end
	end

endmodule
`default_nettype wire

/* File: rtl/lpc_sync2.sv */
`timescale 1ns/10ps
`default_nettype none
// Two flip-flop synchroniser for a bundle of level inputs
module lpc_sync2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Asynchronous levels in, synchronous levels out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// First stage feeds only the second stage
	logic [WIDTH-1:0] meta_r;

	////////////////////////////////////////////////////////////////////
	// Two stages, reset to low
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule
`default_nettype wire

/* File: sim/lpc_phy_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Behavioural PHY; its lane strobe only runs inside frames
module lpc_phy_model (
	// Lanes from the link
	input wire logic [0:7] phy_data_out,
	input wire logic phy_data_oe_out,
	// Lanes, control and events toward the link
	output logic [0:7] phy_data_in,
	output logic [0:1] phy_ctl_in,
	output logic phy_lane_clk_in,
	output logic link_on_in,
	output logic cycle_start_in
);
	logic [7:0] got_q[$]; // Lane values seen at strobes while driven

	// Quiet bus at time zero
	initial begin
		phy_data_in = 8'h00;
		phy_ctl_in = lpc_pkg::CTL_IDLE;
		phy_lane_clk_in = 1'h0;
		link_on_in = 1'h0;
		cycle_start_in = 1'h0;
	end

	// One 160 ns strobe; the link's reply is taken before it moves
	task automatic strobe();
		#80 phy_lane_clk_in = 1'h1;
		if (phy_data_oe_out === 1'h1) begin
			got_q.push_back(phy_data_out);
		end
		#80 phy_lane_clk_in = 1'h0;
	endtask

	// One byte on the top lanes; unused lanes flip so zeros prove nothing
	task automatic rx_byte(input logic [1:0] spd, input logic [7:0] b);
		logic [7:0] m;
		int w;
		w = 2 << spd;
		m = 8'hFF << (8 - w);
		phy_ctl_in = lpc_pkg::CTL_RECEIVE;
		for (int j = 0; j < 8 / w; j++) begin
			phy_data_in = ((b << (j * w)) & m) | (~phy_data_in & ~m);
			strobe();
		end
		#40 phy_ctl_in = lpc_pkg::CTL_IDLE;
		phy_data_in = ~phy_data_in;
	endtask

	// Grants the lanes for n strobes, stalling once before the third strobe
	task automatic grant(input int n);
		#7 phy_ctl_in = lpc_pkg::CTL_GRANT;
		for (int k = 0; k < n; k++) begin
			if (k == 2) begin
				#900; // Strobe stands still
			end
			phy_data_in = ~phy_data_in;
			strobe();
		end
		#40 phy_ctl_in = lpc_pkg::CTL_IDLE;
	endtask

	// Level pulse on link-on (sel 1) or external cycle start (sel 0)
	task automatic pulse(input int sel);
		if (sel == 1) link_on_in = 1'h1;
		else cycle_start_in = 1'h1;
		#200 link_on_in = 1'h0;
		cycle_start_in = 1'h0;
	endtask
endmodule
`default_nettype wire

/* File: sim/lpc_port_chk.sv */
`timescale 1ns/10ps
`default_nettype none
// Watches power, status and mode relations at the block's ports
module lpc_port_chk (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic resetn_in,
	// Host side
	input wire logic cfg_wr_in,
	input wire lpc_pkg::lpc_cfg_t cfg_out,
	input wire logic low_power_out,
	input wire logic link_on_irq_out,
	// PHY side
	input wire logic lps_out,
	input wire logic lreq_out,
	input wire logic phy_data_oe_out,
	input wire logic link_on_in,
	input wire logic legacy_phy_in,
	input wire logic legacy_mode_out,
	input wire logic isolation_barrier_select,
	input wire logic bushold_en_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);

	////////////////////////////////////////////////////////////////////
	logic [3:0] up_r; // Clocks since reset, saturating
	logic [7:0] gap_r; // Clocks since the last status rise
	logic seen_r; // A status rise seen since power came back
	logic lps_d_r; // Status line one clock ago
	// Synchronisers hold stale levels for a few clocks after reset
	wire up_ok = up_r == 4'hF;
	wire lps_rise = lps_out && !lps_d_r;

	// Period counter, restarted by every status rise
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			up_r <= 4'h0;
			gap_r <= 8'h00;
			seen_r <= 1'h0;
			lps_d_r <= 1'h0;
		end else begin
			up_r <= up_ok ? up_r : up_r + 4'h1;
			gap_r <= lps_rise ? 8'h00 : gap_r + 8'h01;
			seen_r <= !low_power_out && (seen_r || lps_rise);
			lps_d_r <= lps_out;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Status pulse: eight clocks high, then low
	sequence s_lps_high;
		lps_out[*8] ##1 !lps_out;
	endsequence
	// Power down seen on two clocks running
	sequence s_pd_held;
		low_power_out[*2];
	endsequence

	a_lps_width: assert property (
		disable iff (!resetn_in || low_power_out) lps_rise |-> s_lps_high)
		else $error("status high time wrong");
	a_lps_period: assert property (lps_rise && seen_r |-> gap_r == 34)
		else $error("status period wrong");
	a_lps_pd_low: assert property (s_pd_held |-> !lps_out)
		else $error("status toggles in power down");
	a_lreq_pd_idle: assert property (s_pd_held |-> !lreq_out)
		else $error("request line busy in power down");
	a_lanes_pd_off: assert property (s_pd_held |-> !phy_data_oe_out)
		else $error("lanes driven in power down");
	a_cfg_only_write: assert property ($changed(cfg_out)
		|-> $past(cfg_wr_in, 2))
		else $error("config changed without a write");
	a_mode_copy: assert property (
		(up_ok && $stable(legacy_phy_in))[*5] |-> legacy_mode_out == legacy_phy_in)
		else $error("generation mode not followed");
	a_bushold_copy: assert property (
		(up_ok && $stable(isolation_barrier_select))[*5] |->
		bushold_en_out == isolation_barrier_select)
		else $error("bushold not followed");
	a_link_irq: assert property ($rose(link_on_in) && up_ok
		|-> ##[1:5] link_on_irq_out)
		else $error("link-on raised no event");
endmodule

bind lpc_port lpc_port_chk u_chk (
	.mclk_in, .resetn_in, .cfg_wr_in, .cfg_out, .low_power_out,
	.link_on_irq_out, .lps_out, .lreq_out, .phy_data_oe_out, .link_on_in,
	.legacy_phy_in, .legacy_mode_out, .isolation_barrier_select,
	.bushold_en_out
);
`default_nettype wire

/* File: sim/lpc_port_tb.sv */
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the PHY port block
module lpc_port_tb;
	localparam int CYC = 64; // Short bus cycle keeps the run brief
	logic mclk_in = 1'h0;
	logic resetn_in = 1'h0;
	logic cfg_wr_in = 1'h0;
	lpc_pkg::lpc_cfg_t cfg_in = 5'h00;
	lpc_pkg::lpc_cfg_t cfg_out;
	logic tx_valid_in = 1'h0;
	logic [7:0] tx_data_in = 8'h00;
	logic lreq_go_in = 1'h0;
	logic [10:0] lreq_bits_in = 11'h000;
	logic legacy_phy_in = 1'h0;
	logic isolation_barrier_select = 1'h0;
	logic power_down_input = 1'h0;
	logic low_power_out, tx_ready_out, rx_valid_out, lreq_busy_out;
	logic [7:0] rx_data_out;
	logic link_on_irq_out, cycle_tick_out, phy_data_oe_out;
	logic [0:7] phy_data_in, phy_data_out;
	logic [0:1] phy_ctl_in;
	logic phy_lane_clk_in, lreq_out, lps_out, link_on_in, legacy_mode_out;
	logic bushold_en_out, aux_clock_out, cycle_start_in, cycle_start_out;
	int bad_count = 0;
	int compares = 0;
	int cyc_n = 0;
	logic [7:0] tb_bytes [4] = '{8'hA5, 8'h3C, 8'hE1, 8'h5A};

	lpc_port #(.CYCLE_CYC(CYC), .TX_DEPTH(4)) uut (
		.mclk_in, .resetn_in, .cfg_wr_in, .cfg_in, .cfg_out, .low_power_out,
		.tx_valid_in, .tx_data_in, .tx_ready_out, .rx_valid_out,
		.rx_data_out, .lreq_go_in, .lreq_bits_in, .lreq_busy_out,
		.link_on_irq_out, .cycle_tick_out, .phy_data_in, .phy_data_out,
		.phy_data_oe_out, .phy_ctl_in, .phy_lane_clk_in, .lreq_out, .lps_out,
		.link_on_in, .legacy_phy_in, .isolation_barrier_select,
		.legacy_mode_out, .bushold_en_out, .power_down_input, .aux_clock_out,
		.cycle_start_in, .cycle_start_out
	);
	lpc_phy_model phy (
		.phy_data_out, .phy_data_oe_out, .phy_data_in, .phy_ctl_in,
		.phy_lane_clk_in, .link_on_in, .cycle_start_in
	);

	////////////////////////////////////////////////////////////////////
	always #10 mclk_in = ~mclk_in;

	// Hang guard, well past the expected run length
	always @(posedge mclk_in) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			bad_count++;
			$display("[ERR] run_cycles exp <20000 got %0d", cyc_n);
			close_out();
		end
	end

	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic chkv(input string nm, input logic [15:0] e, g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	// Inputs move 2 ns after the edge, so no race with sampling
	task automatic step(input int n = 1);
		repeat (n) @(posedge mclk_in);
		#2;
	endtask

	function automatic lpc_pkg::lpc_cfg_t mk(logic [1:0] s, logic e, p);
		mk = {s, e, p, 1'h0};
	endfunction

	task automatic wr_cfg(input lpc_pkg::lpc_cfg_t c);
		cfg_in = c;
		cfg_wr_in = 1'h1;
		step();
		cfg_wr_in = 1'h0;
		step(2);
	endtask

	// Clocks until the chosen line leaves a level (sel 1 cycle, 0 status)
	task automatic run(input int sel, input logic lvl, output int n);
		n = 0;
		while ((sel ? cycle_start_out : lps_out) === lvl && n < 200) begin
			step();
			n++;
		end
	endtask

	// Counts event pulses (sel 1 cycle tick, 0 link-on) over len clocks
	task automatic count(input int sel, input int len, output int n);
		n = 0;
		repeat (len) begin
			step();
			if ((sel ? cycle_tick_out : link_on_irq_out) === 1'h1) n++;
		end
	endtask

	task automatic done(input string nm);
		$display("%s test over, mismatches %0d", nm, bad_count);
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_basic();
		int h, l;
		chkv("cfg_out", 16'h0000, cfg_out);
		chk1("tx_ready_out", 1'h1, tx_ready_out);
		chk1("aux_clock_out", mclk_in, aux_clock_out);
		run(0, 1'h1, h);
		run(0, 1'h0, h);
		run(0, 1'h1, h);
		run(0, 1'h0, l);
		chkv("lps high", 16'h0008, 16'(h));
		chkv("lps period", 16'h0023, 16'(h + l));
		done("basic");
	endtask

	task automatic t_pd();
		logic hi = 1'h0;
		wr_cfg(mk(lpc_pkg::SPD_200, 1'h0, 1'h0));
		// Transmit side is left idle before power down
		power_down_input = 1'h1;
		step(4);
		chk1("low_power_out", 1'h1, low_power_out);
		wr_cfg(mk(lpc_pkg::SPD_400, 1'h1, 1'h0)); // Guard probe
		repeat (40) begin
			step();
			hi = hi | lps_out;
		end
		chk1("lps in power down", 1'h0, hi);
		power_down_input = 1'h0;
		step(4);
		chkv("cfg kept", mk(lpc_pkg::SPD_200, 1'h0, 1'h0), cfg_out);
		wr_cfg(mk(lpc_pkg::SPD_200, 1'h0, 1'h1));
		chk1("soft power down", 1'h1, low_power_out);
		wr_cfg(mk(lpc_pkg::SPD_200, 1'h0, 1'h0));
		chk1("low_power_out", 1'h0, low_power_out);
		done("power");
	endtask

	// Fill the FIFO till it refuses, then drain through a stalling grant
	task automatic t_tx(input logic [1:0] spd);
		int w, c, n = 0;
		logic [7:0] e;
		w = 2 << spd;
		c = 8 / w;
		wr_cfg(mk(spd, 1'h0, 1'h0));
		tx_valid_in = 1'h1;
		while (tx_ready_out === 1'h1 && n < 8) begin
			tx_data_in = tb_bytes[n % 4];
			step();
			n++;
		end
		tx_valid_in = 1'h0;
		chkv("fifo fill", 16'h0004, 16'(n));
		phy.got_q.delete();
		phy.grant(4 * c + 1);
		chkv("chunks", 16'(4 * c), 16'(phy.got_q.size()));
		for (int i = 0; i < 4 * c && i < phy.got_q.size(); i++) begin
			e = (tb_bytes[i / c] << ((i % c) * w)) & (8'hFF << (8 - w));
			chkv("lanes", e, phy.got_q[i]);
		end
		step();
		chk1("fifo empty", 1'h1, tx_ready_out);
		done("transmit");
	endtask

	task automatic t_rx(input logic [1:0] spd);
		int n = 0;
		logic [7:0] g = 8'h00;
		fork
			phy.rx_byte(spd, 8'hB4);
			begin
				while (rx_valid_out !== 1'h1 && n < 200) begin
					step();
					n++;
				end
				g = rx_data_out;
			end
		join
		chkv("rx_data_out", 16'h00B4, g);
		done("receive");
	endtask

	task automatic t_lreq(input logic leg);
		int n = 0;
		logic [15:0] e, fr = 16'h0000;
		legacy_phy_in = leg;
		isolation_barrier_select = !leg;
		step(6);
		chk1("legacy_mode_out", leg, legacy_mode_out);
		chk1("bushold_en_out", !leg, bushold_en_out);
		lreq_bits_in = 11'h5A3;
		lreq_go_in = 1'h1;
		step();
		lreq_go_in = 1'h0;
		while (lreq_out !== 1'h1 && n < 10) begin
			step();
			n++;
		end
		repeat (13) begin
			fr = {fr[14:0], lreq_out};
			step();
		end
		e = leg ? {4'h1, 7'h23, 5'h00} : {4'h1, 11'h5A3, 1'h0};
		chkv("lreq frame", e, fr);
		chk1("lreq_busy_out", 1'h0, lreq_busy_out);
		done("request");
	endtask

	task automatic t_events();
		int n, h, l;
		fork
			phy.pulse(1);
			count(0, 15, n);
		join
		chkv("link-on events", 16'h0001, 16'(n));
		wr_cfg(mk(lpc_pkg::SPD_100, 1'h0, 1'h0));
		run(1, 1'h1, n);
		run(1, 1'h0, n);
		run(1, 1'h1, h);
		run(1, 1'h0, l);
		chkv("cycle high", 16'(CYC / 2), 16'(h));
		chkv("cycle period", 16'(CYC), 16'(h + l));
		wr_cfg(mk(lpc_pkg::SPD_100, 1'h1, 1'h0));
		count(1, 150, n);
		chkv("ticks unpaced", 16'h0000, 16'(n));
		fork
			phy.pulse(0);
			count(1, 20, n);
		join
		chkv("ticks paced", 16'h0001, 16'(n));
		done("events");
	endtask

	initial begin
		step(2);
		resetn_in = 1'h1;
		step();
		t_basic();
		t_pd();
		for (int s = 0; s < 3; s++) begin
			t_tx(2'(s));
			t_rx(2'(s));
		end
		t_lreq(1'h1);
		t_lreq(1'h0);
		t_events();
		close_out();
	end
endmodule
`default_nettype wire
